/* gpio_port.sv */
// Fast parallel I/O ports with masked, set and clear writes and edge interrupts
`timescale 1ns/1ps
// How it works
// - Pins not given to peripherals follow these registers
// - Per-bit direction register, changeable any time
// - Set and clear words touch only one-bits
// - Output latch and live pin readable separately
// - Mask limits output writes and pin reads
// - Byte and halfword accesses touch only lanes
// - One write loads a whole port output
// - Register slave sits directly on fast bus
// - Ports 0 and 2 flag rise, fall, both
// - Edge capture works without a clock
// - Enabled edge raises a clockless wake request
// - Reset leaves every pin an input
// - DMA master reaches the same slave port
module gpio_port
   import gpio_pkg::*;
#(
   parameter int WIDTH = PORT_W
)
(
   // Clock and reset
   input  wire logic                     clk,
   input  wire logic                     rst,
   // Avalon-MM slave
   input  wire logic [ADDR_W-1:0]        avs_address,
   input  wire logic                     avs_read,
   input  wire logic                     avs_write,
   input  wire logic [3:0]               avs_byteenable,
   input  wire logic [31:0]              avs_writedata,
   output logic      [31:0]              avs_readdata,
   output logic                          avs_waitrequest,
   // Peripheral ownership, one bit per pin
   input  wire logic [NPORTS*WIDTH-1:0]  periph_own,
   // Pins
   input  wire logic [NPORTS*WIDTH-1:0]  pin_in,
   output logic      [NPORTS*WIDTH-1:0]  pin_out,
   output logic      [NPORTS*WIDTH-1:0]  pin_oe,
   // Interrupt and wake
   output logic                          irq,
   output logic                          wake_req
);

   bus_req_t req;
   assign req = '{rd: avs_read, wr: avs_write, addr: avs_address,
                  be: avs_byteenable, wdata: avs_writedata};

   logic [WIDTH-1:0] dir_r  [NPORTS];
   logic [WIDTH-1:0] mask_r [NPORTS];
   logic [WIDTH-1:0] out_r  [NPORTS];
   logic [WIDTH-1:0] sy1_r  [NPORTS];
   logic [WIDTH-1:0] sy2_r  [NPORTS];
   logic [WIDTH-1:0] rise_r [2];
   logic [WIDTH-1:0] fall_r [2];
   logic [WIDTH-1:0] stat_r [2];
   logic [WIDTH-1:0] imsk_r [2];
   logic [WIDTH-1:0] evt    [2];
   logic [WIDTH-1:0] ack    [2];
   logic [1:0]       wake_v;
   logic             done_r;
   logic [31:0]      rdata_r;

   // Byte-lane mask from the Avalon byte enables
   function automatic logic [31:0] lane_mask(input logic [3:0] be);
      lane_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
   endfunction : lane_mask

   // Merge write data into a register only on the enabled lanes
   function automatic logic [31:0] lane_merge(input logic [31:0] old,
                                              input logic [31:0] wd,
                                              input logic [3:0]  be);
      lane_merge = (old & ~lane_mask(be)) | (wd & lane_mask(be));
   endfunction : lane_merge

   // One-cycle wait, answer on the second edge: a single slave port serves
   // both CPU and DMA masters since neither needs a bridge in between
   wire access   = (req.rd | req.wr) & ~done_r;
   // Writes land on the edge that sees waitrequest low, never on the stalled one
   wire wr_fire  = req.wr & done_r;
   wire [31:0] lm = lane_mask(req.be);
   wire [1:0]  port_sel = 2'(req.addr[7:5]);
   wire        port_ok  = (req.addr[7:5] < 3'(NPORTS));
   wire [4:0]  roff     = req.addr[4:0] & 5'h1C;
   wire [7:0]  aoff     = {req.addr[7:2], 2'b00};

   assign avs_waitrequest = (req.rd | req.wr) & ~done_r;

   // Per-port register block
   genvar p;
   generate
      for (p = 0; p < NPORTS; p++)
      begin : g_port
         wire sel    = wr_fire & port_ok & (port_sel == 2'(p));
         wire w_dir  = sel & (roff == OFF_DIR);
         wire w_mask = sel & (roff == OFF_MASK);
         wire w_pin  = sel & (roff == OFF_PIN);
         wire w_out  = sel & (roff == OFF_OUT);
         wire w_set  = sel & (roff == OFF_SET);
         wire w_clr  = sel & (roff == OFF_CLR);
         // Mask bit set means the bit is locked out
         wire [WIDTH-1:0] en = lm[WIDTH-1:0] & ~mask_r[p];
         wire [WIDTH-1:0] out_nxt =
              w_out ? ((out_r[p] & ~en) | (req.wdata[WIDTH-1:0] & en)) :
              w_pin ? ((out_r[p] & ~en) | (req.wdata[WIDTH-1:0] & en)) :
              w_set ? (out_r[p] | (req.wdata[WIDTH-1:0] & en))  :
              w_clr ? (out_r[p] & ~(req.wdata[WIDTH-1:0] & en)) :
              out_r[p];

         always_ff @(posedge clk or posedge rst)
         begin
            if (rst)
            begin
               dir_r[p]  <= RST_ZERO[WIDTH-1:0];
               mask_r[p] <= RST_ZERO[WIDTH-1:0];
               out_r[p]  <= RST_ZERO[WIDTH-1:0];
               sy1_r[p]  <= RST_ZERO[WIDTH-1:0];
               sy2_r[p]  <= RST_ZERO[WIDTH-1:0];
            end
            else
            begin
               if (w_dir)
                  dir_r[p] <= lane_merge(dir_r[p], req.wdata, req.be);
               if (w_mask)
                  mask_r[p] <= lane_merge(mask_r[p], req.wdata, req.be);
               out_r[p] <= out_nxt;
               sy1_r[p] <= pin_in[p*WIDTH +: WIDTH];
               sy2_r[p] <= sy1_r[p];
            end
         end

         // Peripheral-owned pins are released to their own function
         assign pin_out[p*WIDTH +: WIDTH] = out_r[p];
         assign pin_oe[p*WIDTH +: WIDTH]  = dir_r[p] & ~periph_own[p*WIDTH +: WIDTH];
      end
   endgenerate

   // Edge interrupt block for ports 0 and 2
   genvar e;
   generate
      for (e = 0; e < 2; e++)
      begin : g_edge
         localparam int PI = (e == 0) ? 0 : 2;
         wire [7:0] base_r = (e == 0) ? OFF_RISE0 : OFF_RISE2;
         wire sel    = wr_fire & (aoff[7:4] == base_r[7:4]);
         wire w_rise = sel & (aoff[3:2] == 2'd0);
         wire w_fall = sel & (aoff[3:2] == 2'd1);
         wire w_stat = sel & (aoff[3:2] == 2'd2);
         wire w_imsk = sel & (aoff[3:2] == 2'd3);
         wire [WIDTH-1:0] clr_bits = w_stat ? (req.wdata[WIDTH-1:0] & lm[WIDTH-1:0])
                                            : '0;

         gpio_edge_cell #(.WIDTH(WIDTH)) u_edge
         (
            .clk         (clk),
            .rst         (rst),
            .pin_raw     (pin_in[PI*WIDTH +: WIDTH]),
            .rise_en     (rise_r[e]),
            .fall_en     (fall_r[e]),
            .ack         (ack[e]),
            .event_pulse (evt[e]),
            .wake        (wake_v[e])
         );
         assign ack[e] = clr_bits;

         always_ff @(posedge clk or posedge rst)
         begin
            if (rst)
            begin
               rise_r[e] <= RST_ZERO[WIDTH-1:0];
               fall_r[e] <= RST_ZERO[WIDTH-1:0];
               stat_r[e] <= RST_ZERO[WIDTH-1:0];
               imsk_r[e] <= RST_ZERO[WIDTH-1:0];
            end
            else
            begin
               if (w_rise)
                  rise_r[e] <= lane_merge(rise_r[e], req.wdata, req.be);
               if (w_fall)
                  fall_r[e] <= lane_merge(fall_r[e], req.wdata, req.be);
               if (w_imsk)
                  imsk_r[e] <= lane_merge(imsk_r[e], req.wdata, req.be);
               // New event wins over a simultaneous write-one clear
               stat_r[e] <= (stat_r[e] & ~clr_bits) | evt[e];
            end
         end
      end
   endgenerate

   assign irq      = |((stat_r[0] & imsk_r[0]) | (stat_r[1] & imsk_r[1]));
   assign wake_req = |wake_v;

   // Read decode
   wire [WIDTH-1:0] pin_masked = sy2_r[port_sel] & ~mask_r[port_sel];
   wire [31:0] port_rd =
        (roff == OFF_DIR)  ? 32'(dir_r[port_sel])  :
        (roff == OFF_MASK) ? 32'(mask_r[port_sel]) :
        (roff == OFF_PIN)  ? 32'(pin_masked)       :
        (roff == OFF_OUT)  ? 32'(out_r[port_sel])  :
        RD_UNMAPPED;
   wire [31:0] edge_rd =
        (aoff == OFF_RISE0) ? 32'(rise_r[0]) :
        (aoff == OFF_FALL0) ? 32'(fall_r[0]) :
        (aoff == OFF_STAT0) ? 32'(stat_r[0]) :
        (aoff == OFF_IMSK0) ? 32'(imsk_r[0]) :
        (aoff == OFF_RISE2) ? 32'(rise_r[1]) :
        (aoff == OFF_FALL2) ? 32'(fall_r[1]) :
        (aoff == OFF_STAT2) ? 32'(stat_r[1]) :
        (aoff == OFF_IMSK2) ? 32'(imsk_r[1]) :
        RD_UNMAPPED;
   wire [31:0] rd_nxt = (port_ok ? port_rd : edge_rd) & lm;

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         done_r  <= 1'b0;
         rdata_r <= RST_ZERO;
      end
      else
      begin
         done_r <= access;
         if (access && req.rd)
            rdata_r <= rd_nxt;
      end
   end

   assign avs_readdata = rdata_r;

endmodule : gpio_port

/* gpio_pkg.sv */
// Shared constants and types for the fast parallel I/O port block
package gpio_pkg;

   localparam int PORT_W    = 32;
   localparam int NPORTS    = 3;
   localparam int ADDR_W    = 8;

   // Per-port register offsets (byte address = port * PORT_STRIDE + offset)
   localparam logic [7:0] PORT_STRIDE = 8'h20;
   localparam logic [4:0] OFF_DIR     = 5'h00;
   localparam logic [4:0] OFF_MASK    = 5'h04;
   localparam logic [4:0] OFF_PIN     = 5'h08;
   localparam logic [4:0] OFF_OUT     = 5'h0C;
   localparam logic [4:0] OFF_SET     = 5'h10;
   localparam logic [4:0] OFF_CLR     = 5'h14;

   // Edge interrupt registers for the two edge-capable ports
   localparam logic [7:0] OFF_RISE0   = 8'h80;
   localparam logic [7:0] OFF_FALL0   = 8'h84;
   localparam logic [7:0] OFF_STAT0   = 8'h88;
   localparam logic [7:0] OFF_IMSK0   = 8'h8C;
   localparam logic [7:0] OFF_RISE2   = 8'h90;
   localparam logic [7:0] OFF_FALL2   = 8'h94;
   localparam logic [7:0] OFF_STAT2   = 8'h98;
   localparam logic [7:0] OFF_IMSK2   = 8'h9C;

   localparam logic [31:0] RST_ZERO   = 32'h0000_0000;
   localparam logic [31:0] RD_UNMAPPED = 32'h0000_0000;
   localparam int          SYNC_STAGES = 2;

   typedef struct packed
   {
      logic                   rd;
      logic                   wr;
      logic [ADDR_W-1:0]      addr;
      logic [3:0]             be;
      logic [31:0]            wdata;
   } bus_req_t;

endpackage : gpio_pkg

/* gpio_edge_cell.sv */
// Asynchronous edge catcher for one port with clocked status transfer
`timescale 1ns/1ps
module gpio_edge_cell
   import gpio_pkg::*;
#(
   parameter int WIDTH = PORT_W
)
(
   // Clock and reset
   input  wire logic             clk,
   input  wire logic             rst,
   // Raw pins and enables
   input  wire logic [WIDTH-1:0] pin_raw,
   input  wire logic [WIDTH-1:0] rise_en,
   input  wire logic [WIDTH-1:0] fall_en,
   // Acknowledge of captured events, one clock pulse per bit
   input  wire logic [WIDTH-1:0] ack,
   // Captured event pulses on clk and asynchronous wake level
   output logic      [WIDTH-1:0] event_pulse,
   output logic                  wake
);

   logic [WIDTH-1:0] cap_r;
   logic [WIDTH-1:0] s1_r;
   logic [WIDTH-1:0] s2_r;
   logic [WIDTH-1:0] s3_r;
   logic [WIDTH-1:0] clr_r;

   // The pin itself clocks the catcher, so edges are held while clk is stopped
   genvar i;
   generate
      for (i = 0; i < WIDTH; i++)
      begin : g_bit
         logic rise_r;
         logic fall_r;
         always_ff @(posedge pin_raw[i] or posedge clr_r[i] or posedge rst)
         begin
            if (rst || clr_r[i])
               rise_r <= 1'b0;
            else if (rise_en[i])
               rise_r <= 1'b1;
         end
         always_ff @(negedge pin_raw[i] or posedge clr_r[i] or posedge rst)
         begin
            if (rst || clr_r[i])
               fall_r <= 1'b0;
            else if (fall_en[i])
               fall_r <= 1'b1;
         end
         assign cap_r[i] = rise_r | fall_r;
      end
   endgenerate

   // Wake needs no clock: any latched enabled edge raises it
   assign wake = |cap_r;

   // Two-stage synchroniser, then a third stage for edge detection
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         s1_r  <= '0;
         s2_r  <= '0;
         s3_r  <= '0;
         clr_r <= '0;
      end
      else
      begin
         s1_r  <= cap_r;
         s2_r  <= s1_r;
         s3_r  <= s2_r;
         // Latch is released once its event reached status; ack also clears
         clr_r <= (s2_r & ~s3_r) | ack;
      end
   end

   assign event_pulse = s2_r & ~s3_r;

endmodule : gpio_edge_cell

/* gpio_port_assertions.sv */
// Bus timing and pin output checks for the parallel I/O port
`timescale 1ns/1ps
module gpio_port_checker
   import gpio_pkg::*;
#(
   parameter int WIDTH = PORT_W
)
(
   // Clock, reset and bus
   input wire logic                    clk,
   input wire logic                    rst,
   input wire logic [ADDR_W-1:0]       avs_address,
   input wire logic                    avs_read,
   input wire logic                    avs_write,
   input wire logic [31:0]             avs_readdata,
   input wire logic                    avs_waitrequest,
   // Pins and interrupt
   input wire logic [NPORTS*WIDTH-1:0] periph_own,
   input wire logic [NPORTS*WIDTH-1:0] pin_out,
   input wire logic [NPORTS*WIDTH-1:0] pin_oe,
   input wire logic                    irq
);
   logic req;
   assign req = avs_read | avs_write;
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   sequence s_asked;
      req && avs_waitrequest;
   endsequence
   sequence s_taken;
      req && !avs_waitrequest;
   endsequence
   a_wait_one: assert property (s_asked |=> s_taken)
      else $error("request not taken after one wait");
   a_wait_rise: assert property (req && !$past(req) |-> avs_waitrequest)
      else $error("first request cycle not stalled");
   a_oe_owned: assert property ((pin_oe & periph_own) == '0)
      else $error("pin driven while owned");
   a_reset_in: assert property ($past(rst) |-> pin_oe == '0 && pin_out == '0 && !irq)
      else $error("outputs active after reset");
   a_out_cause: assert property ($changed(pin_out) |-> $past(avs_write))
      else $error("output changed without write");
   a_oe_cause: assert property ($changed(pin_oe) |-> $past(avs_write) || $changed(periph_own))
      else $error("direction changed without cause");
   a_rdata_cause: assert property ($changed(avs_readdata) |-> avs_read || $past(avs_read))
      else $error("read data changed without read");
   a_unmapped_zero: assert property (s_taken ##0 (avs_read && avs_address == 8'hFC)
      |-> avs_readdata == '0)
      else $error("unmapped read not zero");
endmodule : gpio_port_checker
bind gpio_port gpio_port_checker #(.WIDTH(WIDTH)) chk_i (.clk, .rst, .avs_address, .avs_read,
   .avs_write, .avs_readdata, .avs_waitrequest, .periph_own, .pin_out, .pin_oe, .irq);

/* gpio_pin_model.sv */
// Pins outside the port: outside levels and read-back of driven pins
`timescale 1ns/1ps
module gpio_pin_model
   import gpio_pkg::*;
(
   // From the port
   input  wire logic [NPORTS*PORT_W-1:0] pin_out,
   input  wire logic [NPORTS*PORT_W-1:0] pin_oe,
   // Level the outside world applies
   input  wire logic [NPORTS*PORT_W-1:0] ext_lvl,
   // Seen by the port
   output logic      [NPORTS*PORT_W-1:0] pin_in
);
   // A driven pin reads back its own level, so no outside fight is modelled
   assign pin_in = (pin_out & pin_oe) | (ext_lvl & ~pin_oe);
endmodule : gpio_pin_model

/* test_fast_gpio_port_with_edge_irq.sv */
// Self-checking bench for the parallel I/O port
`timescale 1ns/1ps
module test_fast_gpio_port_with_edge_irq;
   import gpio_pkg::*;
   logic        clk, rst, rd, wr, wq, irq, wake;
   logic [7:0]  adr;
   logic [3:0]  be;
   logic [31:0] wd, rdat, q;
   logic [95:0] own, ext, pin, po, oe;
   int          failures = 0;
   int          checked = 0;
   gpio_port uut (.clk, .rst, .avs_address(adr), .avs_read(rd), .avs_write(wr),
      .avs_byteenable(be), .avs_writedata(wd), .avs_readdata(rdat),
      .avs_waitrequest(wq), .periph_own(own), .pin_in(pin), .pin_out(po),
      .pin_oe(oe), .irq, .wake_req(wake));
   gpio_pin_model pins (.pin_out(po), .pin_oe(oe), .ext_lvl(ext), .pin_in(pin));
   initial
   begin
      clk = 0;
      forever #25 clk = ~clk;
   end
   task automatic chk(input logic [95:0] got, input logic [95:0] exp);
      checked++;
      if (got !== exp)
      begin
         failures++;
         $display("wrong value at %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task automatic end_of_test;
      $display("checks %0d failures %0d", checked, failures);
      if (failures == 0 && checked > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : end_of_test
   // Request held until waitrequest is seen low before the taking edge
   task automatic bus(input logic w, input logic [7:0] a, input logic [3:0] b,
                      input logic [31:0] d);
      logic s;
      adr <= a;
      be <= b;
      wd <= d;
      rd <= !w;
      wr <= w;
      do
      begin
         @(posedge clk);
         s = wq;
         q = rdat;
      end
      while (s !== 1'b0);
      rd <= 1'b0;
      wr <= 1'b0;
      @(posedge clk);
   endtask : bus
   task automatic wr32(input logic [7:0] a, input logic [31:0] d);
      bus(1'b1, a, 4'hF, d);
   endtask : wr32
   task automatic rchk(input logic [7:0] a, input logic [31:0] e);
      bus(1'b0, a, 4'hF, 32'h0);
      chk(q, e);
   endtask : rchk
   task automatic t_drive;
      wr32(8'h00, 32'h0000_00FF);
      wr32(8'h0C, 32'h1234_56A5);
      chk(po[31:0], 32'h1234_56A5);
      chk(oe[31:0], 32'h0000_00FF);
      own[0] <= 1'b1;
      @(posedge clk);
      chk(oe[31:0], 32'h0000_00FE);
      own[0] <= 1'b0;
      // Pin reads pass two synchroniser stages first
      repeat (2) @(posedge clk);
      rchk(8'h08, 32'h0000_00A5);
      rchk(8'h0C, 32'h1234_56A5);
      wr32(8'h10, 32'h0000_0F00);
      wr32(8'h14, 32'h0000_00A0);
      chk(po[31:0], 32'h1234_5F05);
   endtask : t_drive
   task automatic t_mask;
      wr32(8'h04, 32'hFFFF_FF0F);
      wr32(8'h0C, 32'hFFFF_FFFF);
      chk(po[31:0], 32'h1234_5FF5);
      repeat (2) @(posedge clk);
      rchk(8'h08, 32'h0000_00F0);
      wr32(8'h04, 32'h0);
      wr32(8'h2C, 32'h0);
      bus(1'b1, 8'h2C, 4'h2, 32'hFFFF_3CFF);
      chk(po[63:32], 32'h0000_3C00);
      bus(1'b1, 8'h2C, 4'hC, 32'hBEEF_FFFF);
      chk(po[63:32], 32'hBEEF_3C00);
      bus(1'b0, 8'h2C, 4'h4, 32'h0);
      chk(q, 32'h00EF_0000);
      wr32(8'hFC, 32'hFFFF_FFFF);
      rchk(8'hFC, 32'h0);
   endtask : t_mask
   // Edges need a few clocks to pass the synchroniser into status
   task automatic t_edge;
      ext[95:64] <= 32'h1234_5678;
      wr32(8'h80, 32'h0001_0000);
      wr32(8'h8C, 32'h0001_0000);
      rchk(8'h48, 32'h1234_5678);
      ext[16] <= 1'b1;
      // Wake lasts only until the latched edge has reached status
      @(posedge clk);
      chk(wake, 1'b1);
      repeat (5) @(posedge clk);
      chk(irq, 1'b1);
      rchk(8'h88, 32'h0001_0000);
      wr32(8'h88, 32'h0001_0000);
      chk(irq, 1'b0);
      ext[16] <= 1'b0;
      repeat (6) @(posedge clk);
      rchk(8'h88, 32'h0);
      wr32(8'h94, 32'h0000_0003);
      wr32(8'h90, 32'h0000_0002);
      ext[65:64] <= 2'b11;
      repeat (6) @(posedge clk);
      rchk(8'h98, 32'h0000_0002);
      chk(irq, 1'b0);
      ext[65:64] <= 2'b00;
      repeat (6) @(posedge clk);
      rchk(8'h98, 32'h0000_0003);
      wr32(8'h9C, 32'h0000_0003);
      chk(irq, 1'b1);
      wr32(8'h98, 32'h0000_0003);
      chk(irq, 1'b0);
   endtask : t_edge
   initial
   begin
      #200000;
      failures++;
      end_of_test;
   end
   initial
   begin
      {rd, wr, adr, be, wd, own, ext} = '0;
      rst = 1'b1;
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      chk(oe, '0);
      rchk(8'h40, 32'h0);
      t_drive;
      t_mask;
      t_edge;
      end_of_test;
   end
endmodule : test_fast_gpio_port_with_edge_irq
